// >>> src/dcir_defines.svh
// Register map, field positions and fixed values of the distributor config block
// Operation
// - Config word reports lockable shared interrupt count
// - Lock input blocks writes to secure lockables
// - Security bit: one or two security states
// - CPU field holds interface count minus one
// - Line field holds thirty-two ID groups minus one
// - Should-be-zero config bits read zero
// - Ident top byte holds fixed product value
// - Ident holds twelve-bit read-only revision
// - Ident low bits hold manufacturer code
// - Base security word banked per CPU interface
// - Bank chosen from ID, enable, match
// - Only configured shared security words exist
// - Banked private input status word, reset zero
// - Shared input status words, reset zero
// - Input status reachable from secure state only
// - Write-only soft interrupt trigger register
// - Read-only peripheral identification bytes
// - Byte, halfword, word; little-endian data
// - Status words show present input levels
`ifndef DCIR_DEFINES_SVH
`define DCIR_DEFINES_SVH

`define DCIR_ADDR_W        16
`define DCIR_OFF_CONFIG    16'h0004
`define DCIR_OFF_IDENT     16'h0008
`define DCIR_OFF_SEC_BANK  16'h0080
`define DCIR_OFF_SEC_SHR   16'h0084
`define DCIR_OFF_PRIV_STAT 16'h0d00
`define DCIR_OFF_SHR_STAT  16'h0d04
`define DCIR_OFF_SOFT_TRIG 16'h8f00
`define DCIR_OFF_PID8      16'h0fc0
`define DCIR_OFF_PID_UP    16'h0fd0
`define DCIR_OFF_PID_LO    16'h0fe0

`define DCIR_LOCK_LSB      11
`define DCIR_SECX_BIT      10
`define DCIR_CPU_LSB       5
`define DCIR_LINE_LSB      0
`define DCIR_PROD_LSB      24
`define DCIR_REV_LSB       12
`define DCIR_CONT_LSB      8
`define DCIR_PRIV_LSB      16

`define DCIR_RESP_OKAY     2'h0
`define DCIR_RESET_WORD    32'h00000000

`endif

// >>> src/dcir_pkg.sv
// Types shared by the distributor config block
`default_nettype none
package dcir_pkg;
  typedef enum logic [1:0] {RD_IDLE, RD_FETCH, RD_RESP} dcir_rd_state_t;
  typedef enum logic [1:0] {WR_COLLECT, WR_LOOK, WR_RESP} dcir_wr_state_t;

  // Width of the shared line port: one word per 32 shared IDs, at least one word
  function automatic int dcir_shr_w(input int n);
    return 32 * ((((n + 31) / 32 - 1) > 0) ? ((n + 31) / 32 - 1) : 1);
  endfunction
endpackage
`default_nettype wire

// >>> src/dcir_sync.sv
// Two-stage synchroniser for a vector of pin levels
`default_nettype none
module dcir_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level_out
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stage1    <= '0;
      level_out <= '0;
    end
    else
    begin
      stage1    <= pin_in;
      level_out <= stage1;
    end
  end
endmodule
`default_nettype wire

// >>> src/dcir_mem.sv
// Security word store: one write port with bit mask, two registered read ports
`include "dcir_defines.svh"
`default_nettype none
module dcir_mem #(
  parameter int DEPTH = 4,
  parameter int IDX_W = 2
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             wr_en,
  input  wire logic [IDX_W-1:0] wr_index,
  input  wire logic [31:0]      wr_data,
  input  wire logic [31:0]      wr_mask,
  input  wire logic [IDX_W-1:0] rd_a_index,
  output logic      [31:0]      rd_a_data,
  input  wire logic [IDX_W-1:0] rd_b_index,
  output logic      [31:0]      rd_b_data
);
  logic [31:0] store [DEPTH];

  for (genvar e = 0; e < DEPTH; e++)
  begin : g_entry
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        store[e] <= `DCIR_RESET_WORD;
      else if (wr_en && wr_index == IDX_W'(e))
        store[e] <= (store[e] & ~wr_mask) | (wr_data & wr_mask);
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rd_a_data <= `DCIR_RESET_WORD;
      rd_b_data <= `DCIR_RESET_WORD;
    end
    else
    begin
      rd_a_data <= (int'(rd_a_index) < DEPTH) ? store[rd_a_index] : `DCIR_RESET_WORD;
      rd_b_data <= (int'(rd_b_index) < DEPTH) ? store[rd_b_index] : `DCIR_RESET_WORD;
    end
  end
endmodule
`default_nettype wire

// >>> src/dcir_regs.sv
// Distributor configuration, identification and security register bank
`include "dcir_defines.svh"
`default_nettype none
module dcir_regs #(
  parameter int          NUM_CPU    = 8,
  parameter int          NUM_LINES  = 96,
  parameter int          LOCK_COUNT = 31,
  parameter bit          SEC_EXT    = 1'b1,
  parameter int          ID_W       = 8,
  // Identification values below are arbitrary
  parameter logic [7:0]  PRODUCT_ID = 8'h5a,
  parameter logic [11:0] REVISION   = 12'h001,
  parameter logic [3:0]  CONT_CODE  = 4'h3,
  parameter logic [6:0]  MFR_CODE   = 7'h2a,
  parameter logic [7:0]  PID8       = 8'h11,
  parameter logic [31:0] PID_UPPER  = 32'h44332211,
  parameter logic [31:0] PID_LOWER  = 32'h88776655
) (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic                      awvalid,
  output logic                           awready,
  input  wire logic [`DCIR_ADDR_W-1:0]   awaddr,
  input  wire logic [2:0]                awprot,
  input  wire logic [ID_W-1:0]           awid,
  input  wire logic                      wvalid,
  output logic                           wready,
  input  wire logic [31:0]               wdata,
  input  wire logic [3:0]                wstrb,
  output logic                           bvalid,
  input  wire logic                      bready,
  output logic [1:0]                     bresp,
  input  wire logic                      arvalid,
  output logic                           arready,
  input  wire logic [`DCIR_ADDR_W-1:0]   araddr,
  input  wire logic [2:0]                arprot,
  input  wire logic [ID_W-1:0]           arid,
  output logic                           rvalid,
  input  wire logic                      rready,
  output logic [31:0]                    rdata,
  output logic [1:0]                     rresp,
  input  wire logic [NUM_CPU-1:0]        cpu_if_enable,
  input  wire logic [NUM_CPU*ID_W-1:0]   cpu_if_match,
  input  wire logic                      security_lock,
  input  wire logic [NUM_CPU*16-1:0]     private_lines,
  input  wire logic [dcir_pkg::dcir_shr_w(NUM_LINES)-1:0] shared_lines,
  output logic                           soft_trigger_pulse,
  output logic [31:0]                    soft_trigger_data
);
  import dcir_pkg::*;

  //--------------------------------------------------------------------
  // Derived sizes
  //--------------------------------------------------------------------
  localparam int SHR_WORDS = (NUM_LINES + 31) / 32 - 1;
  localparam int SW        = (SHR_WORDS > 0) ? SHR_WORDS : 1;
  localparam int DEPTH     = NUM_CPU + SW;
  localparam int IDX_W     = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int SYNC_W    = 1 + NUM_CPU * 16 + SW * 32;
  localparam logic [31:0] LOCK_VEC = 32'((64'h1 << LOCK_COUNT) - 64'h1);

  localparam logic [31:0] CFG_WORD = {16'h0000,
                                      5'(LOCK_COUNT),
                                      SEC_EXT,
                                      2'h0,
                                      3'(NUM_CPU - 1),
                                      5'((NUM_LINES + 31) / 32 - 1)};
  localparam logic [31:0] IDENT_WORD = {PRODUCT_ID, REVISION,
                                        CONT_CODE, 1'b0, MFR_CODE};

  //--------------------------------------------------------------------
  // Pin synchronisers
  //--------------------------------------------------------------------
  logic [SYNC_W-1:0]      sync_level;
  logic                   lock_s;
  logic [NUM_CPU*16-1:0]  priv_s;
  logic [SW*32-1:0]       shr_s;

  dcir_sync #(.WIDTH(SYNC_W)) u_sync (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .pin_in    ({security_lock, private_lines, shared_lines}),
    .level_out (sync_level)
  );

  assign lock_s = sync_level[SYNC_W-1];
  assign priv_s = sync_level[SW*32 +: NUM_CPU*16];
  assign shr_s  = sync_level[SW*32-1:0];

  //--------------------------------------------------------------------
  // Bank selection and address helpers
  //--------------------------------------------------------------------
  function automatic logic [2:0] pick_bank(input logic [ID_W-1:0] id);
    logic [2:0] sel;
    sel = 3'h0;
    for (int i = NUM_CPU - 1; i >= 0; i--)
      if (cpu_if_enable[i] && cpu_if_match[i*ID_W +: ID_W] == id)
        sel = 3'(i);
    return sel;
  endfunction

  function automatic logic [`DCIR_ADDR_W-1:0] wa(input logic [`DCIR_ADDR_W-1:0] a);
    return {a[`DCIR_ADDR_W-1:2], 2'b00};
  endfunction

  // Security store index; all ones when the offset holds no security word
  function automatic logic [IDX_W-1:0] sec_index(input logic [`DCIR_ADDR_W-1:0] a,
                                                 input logic [2:0]              bank);
    logic [`DCIR_ADDR_W-1:0] off;
    off = wa(a) - `DCIR_OFF_SEC_SHR;
    if (wa(a) == `DCIR_OFF_SEC_BANK)
      return IDX_W'(bank);
    if (SHR_WORDS > 0 && wa(a) >= `DCIR_OFF_SEC_SHR && int'(off >> 2) < SHR_WORDS)
      return IDX_W'(NUM_CPU + int'(off >> 2));
    return '1;
  endfunction

  function automatic logic is_sec(input logic [`DCIR_ADDR_W-1:0] a);
    logic [`DCIR_ADDR_W-1:0] off;
    off = wa(a) - `DCIR_OFF_SEC_SHR;
    return (wa(a) == `DCIR_OFF_SEC_BANK) ||
           (SHR_WORDS > 0 && wa(a) >= `DCIR_OFF_SEC_SHR && int'(off >> 2) < SHR_WORDS);
  endfunction

  //--------------------------------------------------------------------
  // Security word store
  //--------------------------------------------------------------------
  logic [`DCIR_ADDR_W-1:0] aw_addr;
  logic                    aw_sec;
  logic [2:0]              aw_bank;
  logic [31:0]             w_data;
  logic [3:0]              w_strb;
  logic                    mem_wr_en;
  logic [31:0]             mem_wmask;
  logic [31:0]             strobe_mask;
  logic [31:0]             lock_guard;
  logic [31:0]             mem_a_data;
  logic [31:0]             mem_b_data;
  dcir_wr_state_t          wr_state;

  dcir_mem #(.DEPTH(DEPTH), .IDX_W(IDX_W)) u_mem (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .wr_en      (mem_wr_en),
    .wr_index   (sec_index(aw_addr, aw_bank)),
    .wr_data    (w_data),
    .wr_mask    (mem_wmask),
    .rd_a_index (sec_index(araddr, pick_bank(arid))),
    .rd_a_data  (mem_a_data),
    .rd_b_index (sec_index(aw_addr, aw_bank)),
    .rd_b_data  (mem_b_data)
  );

  always_comb
  begin
    for (int b = 0; b < 4; b++)
      strobe_mask[b*8 +: 8] = {8{w_strb[b]}};
    lock_guard = '0;
    if (lock_s && SHR_WORDS > 0 && wa(aw_addr) == `DCIR_OFF_SEC_SHR)
      lock_guard = LOCK_VEC & ~mem_b_data;
    mem_wmask = strobe_mask & ~lock_guard;
    mem_wr_en = (wr_state == WR_LOOK) && is_sec(aw_addr) && aw_sec;
  end

  //--------------------------------------------------------------------
  // Write channel
  //--------------------------------------------------------------------
  logic aw_held;
  logic w_held;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready <= 1'b1;
      aw_held <= 1'b0;
      aw_addr <= '0;
      aw_sec  <= 1'b0;
      aw_bank <= 3'h0;
    end
    else if (awvalid && awready)
    begin
      awready <= 1'b0;
      aw_held <= 1'b1;
      aw_addr <= awaddr;
      aw_sec  <= !awprot[1];
      aw_bank <= pick_bank(awid);
    end
    else if (wr_state == WR_RESP && bready)
    begin
      awready <= 1'b1;
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wready <= 1'b1;
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= 4'h0;
    end
    else if (wvalid && wready)
    begin
      wready <= 1'b0;
      w_held <= 1'b1;
      w_data <= wdata;
      w_strb <= wstrb;
    end
    else if (wr_state == WR_RESP && bready)
    begin
      wready <= 1'b1;
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wr_state <= WR_COLLECT;
      bvalid   <= 1'b0;
      bresp    <= `DCIR_RESP_OKAY;
    end
    else
    begin
      unique case (wr_state)
        WR_COLLECT:
          if (aw_held && w_held)
            wr_state <= WR_LOOK;
        WR_LOOK:
        begin
          bvalid   <= 1'b1;
          bresp    <= `DCIR_RESP_OKAY;
          wr_state <= WR_RESP;
        end
        WR_RESP:
          if (bready)
          begin
            bvalid   <= 1'b0;
            wr_state <= WR_COLLECT;
          end
      endcase
    end
  end

  // Trigger word leaves as a one-cycle pulse; full word, strobes ignored
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      soft_trigger_pulse <= 1'b0;
      soft_trigger_data  <= '0;
    end
    else
    begin
      soft_trigger_pulse <= (wr_state == WR_LOOK) &&
                            wa(aw_addr) == `DCIR_OFF_SOFT_TRIG;
      if (wr_state == WR_LOOK && wa(aw_addr) == `DCIR_OFF_SOFT_TRIG)
        soft_trigger_data <= w_data;
    end
  end

  //--------------------------------------------------------------------
  // Read channel
  //--------------------------------------------------------------------
  dcir_rd_state_t          rd_state;
  logic [`DCIR_ADDR_W-1:0] rd_addr;
  logic                    rd_sec;
  logic [2:0]              rd_bank;
  logic [31:0]             rd_word;
  logic [`DCIR_ADDR_W-1:0] rd_off;

  always_comb
  begin
    rd_off  = wa(rd_addr) - `DCIR_OFF_SHR_STAT;
    rd_word = '0;
    if (wa(rd_addr) == `DCIR_OFF_CONFIG)
      rd_word = CFG_WORD;
    else if (wa(rd_addr) == `DCIR_OFF_IDENT)
      rd_word = IDENT_WORD;
    else if (is_sec(rd_addr))
      rd_word = mem_a_data;
    else if (wa(rd_addr) == `DCIR_OFF_PRIV_STAT)
    begin
      if (rd_sec)
        rd_word[`DCIR_PRIV_LSB +: 16] = priv_s[rd_bank*16 +: 16];
    end
    else if (SHR_WORDS > 0 && wa(rd_addr) >= `DCIR_OFF_SHR_STAT &&
             int'(rd_off >> 2) < SHR_WORDS)
    begin
      if (rd_sec)
        rd_word = shr_s[int'(rd_off >> 2)*32 +: 32];
    end
    else if (wa(rd_addr) == `DCIR_OFF_PID8)
      rd_word = {24'h000000, PID8};
    else if (wa(rd_addr) >= `DCIR_OFF_PID_UP && wa(rd_addr) < `DCIR_OFF_PID_LO)
      rd_word = {24'h000000, PID_UPPER[rd_addr[3:2]*8 +: 8]};
    else if (wa(rd_addr) >= `DCIR_OFF_PID_LO &&
             wa(rd_addr) < `DCIR_OFF_PID_LO + 16'h0010)
      rd_word = {24'h000000, PID_LOWER[rd_addr[3:2]*8 +: 8]};
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rd_state <= RD_IDLE;
      arready  <= 1'b1;
      rvalid   <= 1'b0;
      rdata    <= '0;
      rresp    <= `DCIR_RESP_OKAY;
      rd_addr  <= '0;
      rd_sec   <= 1'b0;
      rd_bank  <= 3'h0;
    end
    else
    begin
      unique case (rd_state)
        RD_IDLE:
          if (arvalid && arready)
          begin
            arready  <= 1'b0;
            rd_addr  <= araddr;
            rd_sec   <= !arprot[1];
            rd_bank  <= pick_bank(arid);
            rd_state <= RD_FETCH;
          end
        RD_FETCH:
        begin
          rvalid   <= 1'b1;
          rdata    <= rd_word;
          rresp    <= `DCIR_RESP_OKAY;
          rd_state <= RD_RESP;
        end
        RD_RESP:
          if (rready)
          begin
            rvalid   <= 1'b0;
            arready  <= 1'b1;
            rd_state <= RD_IDLE;
          end
      endcase
    end
  end

  //--------------------------------------------------------------------
  // Checks
  //--------------------------------------------------------------------
  AST_CFG_LOCK: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_state == RD_FETCH && wa(rd_addr) == `DCIR_OFF_CONFIG |=>
      rdata[15:11] == 5'(LOCK_COUNT))
    else $error("lockable count field wrong");

  AST_LOCK_GUARD: assert property (@(posedge aclk) disable iff (!aresetn)
    mem_wr_en && lock_s && wa(aw_addr) == `DCIR_OFF_SEC_SHR |->
      ##2 (mem_b_data & LOCK_VEC & ~$past(mem_b_data, 2)) == 32'h0)
    else $error("secure lockable bit writable under lock");

  AST_CFG_FIELDS: assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid && $rose(rvalid) && wa(rd_addr) == `DCIR_OFF_CONFIG |->
      rdata[10] == SEC_EXT && rdata[7:5] == 3'(NUM_CPU - 1))
    else $error("security or cpu field wrong");

  AST_CFG_LINES: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(rvalid) && wa(rd_addr) == `DCIR_OFF_CONFIG |->
      rdata[4:0] == 5'((NUM_LINES + 31) / 32 - 1) &&
      rdata[31:16] == 16'h0000 && rdata[9:8] == 2'h0)
    else $error("line field or zero bits wrong");

  AST_IDENT: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(rvalid) && wa(rd_addr) == `DCIR_OFF_IDENT |->
      rdata == {PRODUCT_ID, REVISION, CONT_CODE, 1'b0, MFR_CODE})
    else $error("ident word wrong");

  AST_NONSEC_STATUS: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(rvalid) && !rd_sec && wa(rd_addr) == `DCIR_OFF_PRIV_STAT |->
      rdata == 32'h0)
    else $error("non-secure read saw status");

  AST_TRIGGER: assert property (@(posedge aclk) disable iff (!aresetn)
    soft_trigger_pulse |-> $past(wr_state) == WR_LOOK && !$past(soft_trigger_pulse) &&
      soft_trigger_data == $past(w_data))
    else $error("trigger pulse without matching write");

  AST_READ_LATENCY: assert property (@(posedge aclk) disable iff (!aresetn)
    arvalid && arready |-> !rvalid ##1 !rvalid ##1 rvalid)
    else $error("read answer not two cycles after address");

  AST_WRITE_LATENCY: assert property (@(posedge aclk) disable iff (!aresetn)
    aw_held && w_held && wr_state == WR_COLLECT |-> ##2 bvalid)
    else $error("write answer late");
endmodule
`default_nettype wire

// >>> verif/dcir_axi_master.sv
// Bus master model standing in for the processors on the register bus
`default_nettype none
module dcir_axi_master (
  input  wire logic        aclk,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [15:0]      awaddr,
  output logic [2:0]       awprot,
  output logic [7:0]       awid,
  output logic             wvalid,
  input  wire logic        wready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  input  wire logic        bvalid,
  output logic             bready,
  output logic             arvalid,
  input  wire logic        arready,
  output logic [15:0]      araddr,
  output logic [2:0]       arprot,
  output logic [7:0]       arid,
  input  wire logic        rvalid,
  output logic             rready,
  input  wire logic [31:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, awprot, awid, wdata, wstrb} = '0;
    {araddr, arprot, arid} = '0;
  end
  // -----------------------------------------------------------------
  // Transfers: request held until its own ready, answer awaited
  // -----------------------------------------------------------------
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [7:0] id, input logic [2:0] p, output bit ok);
    ok = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    awid <= id;
    awprot <= p;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 64 && !ok; n++)
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid)
      begin
        bready <= 1'b0;
        ok = 1'b1;
      end
    end
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] id, input logic [2:0] p,
                    output logic [31:0] d, output bit ok);
    ok = 1'b0;
    d = 32'h00000000;
    @(posedge aclk);
    araddr <= a;
    arid <= id;
    arprot <= p;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 64 && !ok; n++)
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid)
      begin
        rready <= 1'b0;
        d = rdata;
        ok = 1'b1;
      end
    end
  endtask
endmodule
`default_nettype wire

// >>> verif/dcir_regs_tb.sv
// Self-checking bench of the distributor configuration register bank
`default_nettype none
module dcir_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NC = 8;
  localparam int NL = 96;
  localparam int LC = 31;
  localparam logic [31:0] PIDU = 32'h44332211;
  localparam logic [31:0] PIDL = 32'h88776655;
  logic        aclk = 1'b0, aresetn = 1'b0, security_lock = 1'b0;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, soft_trigger_pulse;
  logic [15:0] awaddr, araddr;
  logic [2:0]  awprot, arprot;
  logic [7:0]  awid, arid;
  logic [31:0] wdata, rdata, soft_trigger_data, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [7:0]  cpu_if_enable = 8'hff;
  logic [63:0] cpu_if_match = 64'h1716151413121110;
  logic [127:0] private_lines = '0;
  logic [63:0] shared_lines = '0;
  int          miscompares = 0, comparisons = 0, pulses = 0, p0;
  bit          ok;
  always #4 aclk = ~aclk;
  always @(posedge aclk) if (soft_trigger_pulse === 1'b1) pulses++;
  dcir_regs #(.NUM_CPU(NC), .NUM_LINES(NL), .LOCK_COUNT(LC), .SEC_EXT(1'b1), .ID_W(8),
    .PRODUCT_ID(8'h5a), .REVISION(12'h001), .CONT_CODE(4'h3), .MFR_CODE(7'h2a),
    .PID8(8'h11), .PID_UPPER(PIDU), .PID_LOWER(PIDL)) i_dcir_regs (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .awprot(awprot), .awid(awid), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(arprot), .arid(arid),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .cpu_if_enable(cpu_if_enable), .cpu_if_match(cpu_if_match),
    .security_lock(security_lock), .private_lines(private_lines),
    .shared_lines(shared_lines), .soft_trigger_pulse(soft_trigger_pulse),
    .soft_trigger_data(soft_trigger_data));
  dcir_axi_master i_dcir_axi_master (
    .aclk(aclk), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .awprot(awprot), .awid(awid), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .arprot(arprot), .arid(arid),
    .rvalid(rvalid), .rready(rready), .rdata(rdata));
  task automatic give_verdict;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic hung;
    if (!ok)
    begin
      miscompares++;
      give_verdict();
    end
  endtask
  task automatic w(input logic [15:0] a, input logic [31:0] v, input logic [3:0] s,
                   input logic [7:0] id);
    i_dcir_axi_master.wr(a, v, s, id, 3'b000, ok);
    hung();
    chk({30'h0, bresp}, 32'h00000000);
  endtask
  task automatic r(input logic [15:0] a, input logic [7:0] id, input logic [2:0] p);
    i_dcir_axi_master.rd(a, id, p, d, ok);
    hung();
    chk({30'h0, rresp}, 32'h00000000);
  endtask
  // -----------------------------------------------------------------
  // Scenarios
  // -----------------------------------------------------------------
  task automatic t_config_ident;
    w(16'h0004, 32'hffffffff, 4'hf, 8'h10);
    r(16'h0004, 8'h10, 3'b000);
    chk(d, {16'h0, 5'(LC), 1'b1, 2'b0, 3'(NC - 1), 5'((NL + 31) / 32 - 1)});
    chk(32'(int'(d[4:0]) * 32 < NL && NL <= (int'(d[4:0]) + 1) * 32), 32'h1);
    r(16'h0008, 8'h10, 3'b000);
    chk(d, {8'h5a, 12'h001, 4'h3, 1'b0, 7'h2a});
  endtask
  task automatic t_bank;
    w(16'h0080, 32'hdeadbeef, 4'b0101, 8'h11);
    r(16'h0080, 8'h11, 3'b000);
    chk(d, 32'h00ad00ef);
    r(16'h0080, 8'h10, 3'b000);
    chk(d, 32'h00000000);
    r(16'h0080, 8'h77, 3'b000);
    chk(d, 32'h00000000);
    i_dcir_axi_master.wr(16'h0080, 32'hffffffff, 4'hf, 8'h11, 3'b010, ok);
    hung();
    r(16'h0080, 8'h11, 3'b000);
    chk(d, 32'h00ad00ef);
    cpu_if_match[15:8] <= 8'h55;
    r(16'h0080, 8'h55, 3'b000);
    chk(d, 32'h00ad00ef);
    cpu_if_enable <= 8'hfd;
    r(16'h0080, 8'h55, 3'b000);
    chk(d, 32'h00000000);
    cpu_if_enable <= 8'hff;
    cpu_if_match[15:8] <= 8'h11;
  endtask
  task automatic t_lock;
    security_lock <= 1'b1;
    repeat (4) @(posedge aclk);
    w(16'h0084, 32'hffffffff, 4'hf, 8'h10);
    r(16'h0084, 8'h10, 3'b000);
    chk(d, 32'h80000000);
    security_lock <= 1'b0;
    repeat (4) @(posedge aclk);
    w(16'h0084, 32'h00000001, 4'b0001, 8'h10);
    r(16'h0084, 8'h10, 3'b000);
    chk(d, 32'h80000001);
    r(16'h008c, 8'h10, 3'b000);
    chk(d, 32'h00000000);
  endtask
  task automatic t_status;
    r(16'h0d00, 8'h10, 3'b000);
    chk(d, 32'h00000000);
    private_lines[31:16] <= 16'hc35a;
    shared_lines <= 64'h0123456789abcdef;
    repeat (4) @(posedge aclk);
    r(16'h0d00, 8'h11, 3'b000);
    chk(d, 32'hc35a0000);
    r(16'h0d00, 8'h10, 3'b000);
    chk(d, 32'h00000000);
    r(16'h0d00, 8'h11, 3'b010);
    chk(d, 32'h00000000);
    r(16'h0d04, 8'h10, 3'b000);
    chk(d, 32'h89abcdef);
    r(16'h0d08, 8'h10, 3'b000);
    chk(d, 32'h01234567);
  endtask
  task automatic t_trigger_ident;
    p0 = pulses;
    w(16'h8f00, 32'h01028003, 4'hf, 8'h10);
    @(posedge aclk);
    chk(32'(pulses - p0), 32'h00000001);
    chk(soft_trigger_data, 32'h01028003);
    r(16'h8f00, 8'h10, 3'b000);
    chk(d, 32'h00000000);
    r(16'h0fc0, 8'h10, 3'b000);
    chk(d, 32'h00000011);
    r(16'h0fd0, 8'h10, 3'b000);
    chk(d, {24'h0, PIDU[7:0]});
    r(16'h0fe4, 8'h10, 3'b000);
    chk(d, {24'h0, PIDL[15:8]});
    w(16'h000c, 32'hffffffff, 4'hf, 8'h10);
    r(16'h000c, 8'h10, 3'b000);
    chk(d, 32'h00000000);
  endtask
  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_config_ident();
    t_bank();
    t_lock();
    t_status();
    t_trigger_ident();
    give_verdict();
  end
endmodule
`default_nettype wire
